// ===== inc/size_select_params.svh
// constants for the operand and address size selector
`ifndef SIZE_SELECT_PARAMS_SVH
`define SIZE_SELECT_PARAMS_SVH
`define OPSIZE_PREFIX_BYTE 8'h66
`define ADDRSIZE_PREFIX_BYTE 8'h67
`define OFFSET16_LIMIT 32'h0000FFFF
`define MAX_PREFIX_BYTES 4'hE
`endif

// ===== inc/size_select_pkg.sv
// types for the operand and address size selector
`default_nettype none
package size_select_pkg;
  typedef enum logic {SIZE_16, SIZE_32} width_type;
  typedef enum logic [1:0]
  {
    MODE_REAL,
    MODE_PROTECTED,
    MODE_V86,
    MODE_SYSTEM_MANAGEMENT
  } cpu_mode_type;
endpackage
`default_nettype wire

// ===== rtl/prefix_scan.sv
// prefix byte scanner: gathers size overrides for one instruction
`timescale 1ns/1ps
`default_nettype none
`include "size_select_params.svh"
module prefix_scan
(
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic byte_valid,
  input wire logic [7:0] byte_data,
  input wire logic insn_end,
  output logic op_override,
  output logic addr_override
);
  logic op_seen_q;
  logic op_seen_d;
  logic addr_seen_q;
  logic addr_seen_d;

  // override flags latch and clear at instruction end
  always_comb
  begin
    op_seen_d = op_seen_q;
    addr_seen_d = addr_seen_q;
    if (insn_end)
    begin
      op_seen_d = 1'b0;
      addr_seen_d = 1'b0;
    end
    else if (byte_valid)
    begin
      if (byte_data == `OPSIZE_PREFIX_BYTE)
        op_seen_d = 1'b1;
      if (byte_data == `ADDRSIZE_PREFIX_BYTE)
        addr_seen_d = 1'b1;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      op_seen_q <= 1'b0;
      addr_seen_q <= 1'b0;
    end
    else
    begin
      op_seen_q <= op_seen_d;
      addr_seen_q <= addr_seen_d;
    end
  end

  // current prefix byte counts as well as earlier ones
  assign op_override = op_seen_q | (byte_valid & (byte_data == `OPSIZE_PREFIX_BYTE));
  assign addr_override = addr_seen_q | (byte_valid & (byte_data == `ADDRSIZE_PREFIX_BYTE));
endmodule
`default_nettype wire

// ===== rtl/operand_address_size_select.sv
// operand, address and offset width selection per instruction; stack pointer width follows stack_size_32 every cycle
`timescale 1ns/1ps
`default_nettype none
`include "size_select_params.svh"
module operand_address_size_select
(
  input wire logic ref_clk,
  input wire logic srst,
  input wire size_select_pkg::cpu_mode_type cpu_mode,
  input wire logic code_default_32,
  input wire logic stack_size_32,
  input wire logic byte_valid,
  input wire logic [7:0] byte_data,
  input wire logic insn_end,
  input wire logic implicit_stack,
  input wire logic explicit_stack,
  input wire logic gateless_transfer,
  input wire logic [31:0] raw_address,
  input wire logic [31:0] raw_target,
  output logic operand_is_32,
  output logic address_is_32,
  output logic stack_ptr_is_32,
  output logic offset_is_32,
  output logic [31:0] effective_address,
  output logic [31:0] target_offset,
  output logic sizes_valid
);
  // ----------------------------------------
  // prefix capture
  // ----------------------------------------
  logic op_override;
  logic addr_override;

  prefix_scan scan_u
  (
    .ref_clk(ref_clk),
    .srst(srst),
    .byte_valid(byte_valid),
    .byte_data(byte_data),
    .insn_end(insn_end),
    .op_override(op_override),
    .addr_override(addr_override)
  );

  // ----------------------------------------
  // size decode
  // ----------------------------------------
  // default width from mode and descriptor flag
  function automatic logic seg_default(size_select_pkg::cpu_mode_type m, logic d);
    seg_default = (m == size_select_pkg::MODE_PROTECTED) ? d : 1'b0;
  endfunction

  // trim a 32-bit value to 16 bits when narrow
  function automatic logic [31:0] trim(logic wide, logic [31:0] v);
    trim = wide ? v : (v & `OFFSET16_LIMIT);
  endfunction

  logic def32;
  logic op32;
  logic ad32;
  assign def32 = seg_default(cpu_mode, code_default_32);
  assign op32 = def32 ^ op_override;
  assign ad32 = def32 ^ addr_override;

  // ----------------------------------------
  // output registers
  // ----------------------------------------
  logic operand_is_32_d;
  logic address_is_32_d;
  logic stack_ptr_is_32_d;
  logic offset_is_32_d;
  logic [31:0] effective_address_d;
  logic [31:0] target_offset_d;
  logic sizes_valid_d;

  // results computed at instruction end; stack pointer width follows stack_size_32 every cycle
  always_comb
  begin
    operand_is_32_d = operand_is_32;
    address_is_32_d = address_is_32;
    stack_ptr_is_32_d = stack_size_32;
    offset_is_32_d = offset_is_32;
    effective_address_d = effective_address;
    target_offset_d = target_offset;
    sizes_valid_d = 1'b0;
    if (insn_end)
    begin
      sizes_valid_d = 1'b1;
      operand_is_32_d = op32;
      address_is_32_d = ad32;
      offset_is_32_d = op32;
      if (implicit_stack && !explicit_stack)
        effective_address_d = trim(stack_size_32, raw_address);
      else
        effective_address_d = trim(ad32, raw_address);
      if (gateless_transfer)
        target_offset_d = trim(op32, raw_target);
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      operand_is_32 <= 1'b0;
      address_is_32 <= 1'b0;
      stack_ptr_is_32 <= 1'b0;
      offset_is_32 <= 1'b0;
      effective_address <= 32'h00000000;
      target_offset <= 32'h00000000;
      sizes_valid <= 1'b0;
    end
    else
    begin
      operand_is_32 <= operand_is_32_d;
      address_is_32 <= address_is_32_d;
      stack_ptr_is_32 <= stack_ptr_is_32_d;
      offset_is_32 <= offset_is_32_d;
      effective_address <= effective_address_d;
      target_offset <= target_offset_d;
      sizes_valid <= sizes_valid_d;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  sequence plain_end_s;
    insn_end && !op_override && !addr_override;
  endsequence

  // one copy of the operand-size prefix that does not end the instruction
  sequence op_byte_s;
    byte_valid && byte_data == `OPSIZE_PREFIX_BYTE && !insn_end;
  endsequence

  // two operand-size prefix copies in a row, then the instruction ends
  sequence op_pair_end_s;
    op_byte_s ##1 op_byte_s ##1 insn_end;
  endsequence

  // implicit stack access ending its instruction on a 16-bit stack
  sequence stk16_end_s;
    insn_end && implicit_stack && !explicit_stack && !stack_size_32;
  endsequence

  // implicit stack access ending its instruction on a 32-bit stack
  sequence stk32_end_s;
    insn_end && implicit_stack && !explicit_stack && stack_size_32;
  endsequence

  // explicit stack reference ending its instruction
  sequence expl_end_s;
    insn_end && explicit_stack;
  endsequence

  // instruction end without a pointer-based transfer
  sequence no_xfer_end_s;
    insn_end && !gateless_transfer;
  endsequence

  // pointer-based transfer ending with a 32-bit operand size
  sequence xfer32_s;
    insn_end && gateless_transfer && op32;
  endsequence

  // upper address half clear, for the narrow address checks
  logic addr_hi_zero;
  assign addr_hi_zero = (effective_address[31:16] == 16'h0000);

  op_invert_a: assert property (insn_end |=> operand_is_32 == ($past(def32) ^ $past(op_override)))
    else $error("operand size not inverted by prefix");
  addr_invert_a: assert property (insn_end |=> address_is_32 == ($past(def32) ^ $past(addr_override)))
    else $error("address size not inverted by prefix");
  default32_plain_a: assert property (plain_end_s and def32 |=> operand_is_32 && address_is_32)
    else $error("32-bit default not applied");
  default16_plain_a: assert property (plain_end_s and !def32 |=> !operand_is_32 && !address_is_32)
    else $error("16-bit default not applied");
  prefix_once_a: assert property (insn_end ##1 (insn_end && !(byte_valid && byte_data == `OPSIZE_PREFIX_BYTE)) |-> !op_override)
    else $error("override leaked into next instruction");
  legacy16_a: assert property (insn_end && cpu_mode != size_select_pkg::MODE_PROTECTED && !op_override |=> !operand_is_32)
    else $error("legacy mode not 16-bit default");
  narrow_addr_a: assert property (sizes_valid && !address_is_32 && !$past(implicit_stack) |-> effective_address[31:16] == 16'h0000)
    else $error("16-bit address beyond 64 KBytes");
  stack_width_a: assert property (1'b1 |=> stack_ptr_is_32 == $past(stack_size_32))
    else $error("stack pointer width not following flag");
  offset_width_a: assert property (sizes_valid |-> offset_is_32 == operand_is_32)
    else $error("offset width differs from operand size");
  narrow_target_a: assert property (insn_end && gateless_transfer && !op32 |=> target_offset[31:16] == 16'h0000)
    else $error("16-bit transfer beyond FFFFH");
  double_prefix_a: assert property (byte_valid && byte_data == `OPSIZE_PREFIX_BYTE ##1 byte_valid && byte_data == `OPSIZE_PREFIX_BYTE && !insn_end |-> op_override)
    else $error("repeated prefix toggled size");

  // prefix copies, stack widths, result pulse and offset handling
  repeat_op_a: assert property (op_pair_end_s |=> operand_is_32 != $past(def32))
    else $error("two operand prefixes cancelled each other");
  stk_narrow_a: assert property (stk16_end_s |=> addr_hi_zero)
    else $error("implicit access on 16-bit stack not trimmed");
  stk_wide_a: assert property (stk32_end_s |=> effective_address == $past(raw_address))
    else $error("implicit access on 32-bit stack trimmed");
  expl_narrow_a: assert property (expl_end_s and !ad32 |=> addr_hi_zero)
    else $error("explicit stack reference ignored address size");
  valid_pulse_a: assert property (insn_end |=> sizes_valid)
    else $error("result strobe missing after instruction end");
  valid_idle_a: assert property (!insn_end |=> !sizes_valid)
    else $error("result strobe without instruction end");
  target_hold_a: assert property (no_xfer_end_s |=> $stable(target_offset))
    else $error("target offset changed without a transfer");
  target_wide_a: assert property (xfer32_s |=> target_offset == $past(raw_target))
    else $error("32-bit transfer offset trimmed");
endmodule
`default_nettype wire

// ===== verif/tb_top.sv
// self-checking testbench for the operand and address size selector
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  size_select_pkg::cpu_mode_type cpu_mode = size_select_pkg::MODE_PROTECTED;
  logic code_default_32 = 1'b0;
  logic stack_size_32 = 1'b0;
  logic byte_valid = 1'b0;
  logic [7:0] byte_data = 8'h00;
  logic insn_end = 1'b0;
  logic implicit_stack = 1'b0;
  logic explicit_stack = 1'b0;
  logic gateless_transfer = 1'b0;
  logic [31:0] raw_address = 32'h89AB_CDEF;
  logic [31:0] raw_target = 32'h1234_5678;
  logic operand_is_32, address_is_32, stack_ptr_is_32, offset_is_32, sizes_valid;
  logic [31:0] effective_address, target_offset;
  int n_mismatch = 0;
  int checks = 0;
  // ---------------------------------------------------------------
  // clock, design and shared tasks
  // ---------------------------------------------------------------
  always #5 ref_clk = ~ref_clk;
  operand_address_size_select u_operand_address_size_select (.ref_clk(ref_clk), .srst(srst),
    .cpu_mode(cpu_mode), .code_default_32(code_default_32), .stack_size_32(stack_size_32),
    .byte_valid(byte_valid), .byte_data(byte_data), .insn_end(insn_end),
    .implicit_stack(implicit_stack), .explicit_stack(explicit_stack),
    .gateless_transfer(gateless_transfer), .raw_address(raw_address), .raw_target(raw_target),
    .operand_is_32(operand_is_32), .address_is_32(address_is_32),
    .stack_ptr_is_32(stack_ptr_is_32), .offset_is_32(offset_is_32),
    .effective_address(effective_address), .target_offset(target_offset),
    .sizes_valid(sizes_valid));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic tick();
    @(posedge ref_clk);
    #1;
  endtask
  // one instruction: nop/nad prefix copies, then the opcode byte with insn_end
  task automatic insn(input logic d32, input int nop, input int nad, input logic expl,
                      input logic jump);
    logic def;
    logic op;
    logic ad;
    def = (cpu_mode == size_select_pkg::MODE_PROTECTED) && d32;
    op = def ^ (nop > 0);
    ad = def ^ (nad > 0);
    code_default_32 = d32;
    byte_valid = 1'b1;
    for (int i = 0; i < nop + nad; i++)
    begin
      byte_data = (i < nop) ? 8'h66 : 8'h67;
      tick();
    end
    byte_data = 8'h8B;
    insn_end = 1'b1;
    explicit_stack = expl;
    implicit_stack = expl;
    gateless_transfer = jump;
    tick();
    byte_valid = 1'b0;
    insn_end = 1'b0;
    explicit_stack = 1'b0;
    implicit_stack = 1'b0;
    gateless_transfer = 1'b0;
    check(32'(sizes_valid), 32'h1);
    check(32'(operand_is_32), 32'(op));
    check(32'(address_is_32), 32'(ad));
    check(32'(offset_is_32), 32'(op));
    check(effective_address, ad ? raw_address : {16'h0000, raw_address[15:0]});
    if (jump)
      check(target_offset, op ? raw_target : {16'h0000, raw_target[15:0]});
    tick();
    check(32'(sizes_valid), 32'h0);
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic size_table();
    for (int d = 0; d < 2; d++)
      for (int p = 0; p < 4; p++)
        insn(d[0], p % 2, p / 2, 1'b0, 1'b1);
  endtask
  task automatic override_expires();
    insn(1'b1, 1, 1, 1'b0, 1'b1);
    insn(1'b1, 0, 0, 1'b0, 1'b1);
  endtask
  task automatic native_modes();
    for (int m = 0; m < 4; m++)
    begin
      cpu_mode = size_select_pkg::cpu_mode_type'(m);
      insn(1'b1, 0, 0, 1'b0, 1'b1);
      insn(1'b1, 1, 0, 1'b0, 1'b1);
      insn(1'b0, 0, 1, 1'b0, 1'b1);
    end
    cpu_mode = size_select_pkg::MODE_PROTECTED;
  endtask
  task automatic repeated_prefix();
    insn(1'b0, 3, 2, 1'b0, 1'b1);
    insn(1'b1, 2, 3, 1'b0, 1'b1);
    insn(1'b0, 2, 0, 1'b0, 1'b1);
  endtask
  task automatic stack_width();
    stack_size_32 = 1'b1;
    tick();
    check(32'(stack_ptr_is_32), 32'h1);
    insn(1'b0, 0, 0, 1'b1, 1'b0);
    insn(1'b0, 0, 1, 1'b1, 1'b0);
    stack_size_32 = 1'b0;
    tick();
    check(32'(stack_ptr_is_32), 32'h0);
  endtask
  // two instructions back to back: the second must not inherit prefixes
  task automatic back_to_back();
    code_default_32 = 1'b0;
    byte_valid = 1'b1;
    byte_data = 8'h66;
    tick();
    byte_data = 8'h67;
    tick();
    byte_data = 8'h8B;
    insn_end = 1'b1;
    tick();
    check(32'(operand_is_32), 32'h1);
    check(32'(address_is_32), 32'h1);
    tick();
    byte_valid = 1'b0;
    insn_end = 1'b0;
    check(32'(operand_is_32), 32'h0);
    check(32'(address_is_32), 32'h0);
    check(32'(sizes_valid), 32'h1);
    tick();
    check(32'(sizes_valid), 32'h0);
  endtask
  // implicit stack access: width follows the stack flag, not the address size
  task automatic implicit_push();
    for (int s = 0; s < 2; s++)
    begin
      stack_size_32 = s[0];
      code_default_32 = !s[0];
      byte_valid = 1'b1;
      byte_data = 8'h50;
      insn_end = 1'b1;
      implicit_stack = 1'b1;
      tick();
      byte_valid = 1'b0;
      insn_end = 1'b0;
      implicit_stack = 1'b0;
      check(32'(stack_ptr_is_32), 32'(s));
      check(effective_address, s[0] ? raw_address : {16'h0000, raw_address[15:0]});
      tick();
    end
    stack_size_32 = 1'b0;
  endtask
  // matching call and return sizes, and the 16-bit offset end points
  task automatic transfer_pairs();
    insn(1'b0, 1, 0, 1'b0, 1'b1);
    insn(1'b1, 0, 0, 1'b0, 1'b1);
    raw_target = 32'h0000_FFFF;
    insn(1'b1, 1, 0, 1'b0, 1'b1);
    raw_target = 32'h0001_0000;
    insn(1'b0, 0, 0, 1'b0, 1'b1);
    insn(1'b0, 1, 0, 1'b0, 1'b1);
    raw_target = 32'h1234_5678;
    raw_address = 32'h0001_0000;
    insn(1'b0, 0, 0, 1'b0, 1'b0);
    insn(1'b0, 0, 1, 1'b0, 1'b0);
    raw_address = 32'h89AB_CDEF;
  endtask
  // ---------------------------------------------------------------
  // main sequence and hang guard
  // ---------------------------------------------------------------
  initial
  begin
    repeat (20) @(posedge ref_clk);
    #1;
    check({26'h0, operand_is_32, address_is_32, offset_is_32, sizes_valid, 2'h0}, 32'h0);
    srst = 1'b0;
    size_table();
    override_expires();
    native_modes();
    repeated_prefix();
    stack_width();
    back_to_back();
    implicit_push();
    transfer_pairs();
    tally_and_finish();
  end
  initial
  begin
    #100000;
    n_mismatch++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
